// *** rtl/epc_host.sv ***
/*
  host controller for a parallel eeprom with software data protection.
  issues reads, page writes preceded by the protect-enable sequence,
  and the six-step protect-disable sequence, then waits for programming
  by polling the completion bit, data bit 7, after writes, or for PROG_CYC after commands.
  assumes one 8-bit lane selected by lane_select_n, pins through epc_bus_cycle.
*/
`timescale 1ns/1ns
module epc_host
  import epc_pkg::*;
#(
  parameter logic [ADDR_W-1:0] EN_ADDR0  = 17'h05555,
  parameter logic [ADDR_W-1:0] EN_ADDR1  = 17'h02aaa,
  parameter logic [ADDR_W-1:0] EN_ADDR2  = 17'h05555,
  parameter logic [DATA_W-1:0] EN_DATA0  = 8'haa,
  parameter logic [DATA_W-1:0] EN_DATA1  = 8'h55,
  parameter logic [DATA_W-1:0] EN_DATA2  = 8'ha0,
  parameter logic [ADDR_W-1:0] DIS_ADDR0 = 17'h05555,
  parameter logic [ADDR_W-1:0] DIS_ADDR1 = 17'h02aaa,
  parameter logic [ADDR_W-1:0] DIS_ADDR2 = 17'h05555,
  parameter logic [ADDR_W-1:0] DIS_ADDR3 = 17'h05555,
  parameter logic [ADDR_W-1:0] DIS_ADDR4 = 17'h02aaa,
  parameter logic [ADDR_W-1:0] DIS_ADDR5 = 17'h05555,
  parameter logic [DATA_W-1:0] DIS_DATA0 = 8'haa,
  parameter logic [DATA_W-1:0] DIS_DATA1 = 8'h55,
  parameter logic [DATA_W-1:0] DIS_DATA2 = 8'h80,
  parameter logic [DATA_W-1:0] DIS_DATA3 = 8'haa,
  parameter logic [DATA_W-1:0] DIS_DATA4 = 8'h55,
  parameter logic [DATA_W-1:0] DIS_DATA5 = 8'h20,
  parameter int unsigned       PROG_CYC  = PROGRAM_CYC
)(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  // user request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [1:0]        req_op,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic              req_last,
  // user answer
  output logic                   rsp_valid_q,
  output logic [DATA_W-1:0]      rsp_rdata_q,
  output logic                   rsp_timeout_q,
  output logic                   protect_on_q,
  // eeprom pins
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   lane_select_n,
  output logic                   out_en_n,
  output logic                   wr_en_n,
  output logic [DATA_W-1:0]      command_byte_lines_o,
  output logic                   command_byte_lines_oe,
  input  wire logic [DATA_W-1:0] command_byte_lines_i
);

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_CMD  = 3'h1,
    H_DATA = 3'h2,
    H_WAIT = 3'h3,
    H_POLL = 3'h4,
    H_READ = 3'h5
  } host_state_e;

  // ----------------------------------------------------------------
  // command tables
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] seq_addr [6];
  logic [DATA_W-1:0] seq_data [6];

  host_state_e       st_q;
  epc_op_e           op_q;
  logic [2:0]        step_q;
  logic [7:0]        nbytes_q;
  logic [CNT_W-1:0]  tmr_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] data_q;
  logic [ADDR_W-1:0] last_addr_q;
  logic [DATA_W-1:0] last_data_q;
  logic              last_q;
  logic              bc_busy_q;
  logic              bc_start;
  logic              bc_done;
  logic [DATA_W-1:0] bc_rdata;

  wire is_unprot   = (op_q == EPC_OP_UNPROT);
  wire [2:0] nsteps = is_unprot ? 3'h6 : 3'h3;

  always_comb begin
    seq_addr[0] = is_unprot ? DIS_ADDR0 : EN_ADDR0;
    seq_addr[1] = is_unprot ? DIS_ADDR1 : EN_ADDR1;
    seq_addr[2] = is_unprot ? DIS_ADDR2 : EN_ADDR2;
    seq_addr[3] = DIS_ADDR3;
    seq_addr[4] = DIS_ADDR4;
    seq_addr[5] = DIS_ADDR5;
    seq_data[0] = is_unprot ? DIS_DATA0 : EN_DATA0;
    seq_data[1] = is_unprot ? DIS_DATA1 : EN_DATA1;
    seq_data[2] = is_unprot ? DIS_DATA2 : EN_DATA2;
    seq_data[3] = DIS_DATA3;
    seq_data[4] = DIS_DATA4;
    seq_data[5] = DIS_DATA5;
  end

  // ----------------------------------------------------------------
  // pin cycle selection
  // ----------------------------------------------------------------
  wire               cyc_write = (st_q == H_CMD) || (st_q == H_DATA);
  wire [ADDR_W-1:0]  cyc_addr  = (st_q == H_CMD)  ? seq_addr[step_q] :
                                 (st_q == H_DATA) ? addr_q :
                                 (st_q == H_POLL) ? last_addr_q : addr_q;
  wire [DATA_W-1:0]  cyc_data  = (st_q == H_CMD) ? seq_data[step_q] : data_q;

  wire   page_full = (nbytes_q == 8'(PAGE_MAX));
  // byte load window nearly spent: stop waiting for more bytes
  wire   load_late = (tmr_q >= CNT_W'(BYTE_LOAD_CYC - 3 * WRITE_PULSE_CYC));
  wire   same_page = (req_addr[ADDR_W-1:$clog2(PAGE_MAX)] == last_addr_q[ADDR_W-1:$clog2(PAGE_MAX)]);
  // only a further write to the open page is taken while it loads
  wire   page_more = (st_q == H_WAIT) && !last_q && !page_full && !load_late &&
                     (epc_op_e'(req_op) == EPC_OP_WRITE) && same_page;
  assign req_ready = ((st_q == H_IDLE) || page_more) && !bc_busy_q;
  wire   req_take  = req_valid && req_ready;
  wire   poll_ok   = (bc_rdata[7] == last_data_q[7]);
  wire   prog_over = (tmr_q >= CNT_W'(PROG_CYC));

  assign bc_start = !bc_busy_q &&
                    ((st_q == H_CMD) || (st_q == H_DATA) || (st_q == H_POLL) || (st_q == H_READ));

  epc_bus_cycle u_cycle (
    .clk_sys              (clk_sys),
    .resetn               (resetn),
    .start                (bc_start),
    .is_write             (cyc_write),
    .addr                 (cyc_addr),
    .wdata                (cyc_data),
    .done                 (bc_done),
    .rdata_q              (bc_rdata),
    .mem_addr_q           (mem_addr),
    .chip_sel_n_q         (lane_select_n),
    .out_en_n_q           (out_en_n),
    .wr_en_n_q            (wr_en_n),
    .command_byte_lines_o (command_byte_lines_o),
    .command_byte_lines_oe(command_byte_lines_oe),
    .command_byte_lines_i (command_byte_lines_i)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bc_busy_q <= 1'b0;
    end else if (bc_start) begin
      bc_busy_q <= 1'b1;
    end else if (bc_done) begin
      bc_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q          <= H_IDLE;
      op_q          <= EPC_OP_READ;
      step_q        <= '0;
      nbytes_q      <= '0;
      tmr_q         <= '0;
      addr_q        <= '0;
      data_q        <= '0;
      last_addr_q   <= '0;
      last_data_q   <= '0;
      last_q        <= 1'b0;
      rsp_valid_q   <= 1'b0;
      rsp_rdata_q   <= '0;
      rsp_timeout_q <= 1'b0;
      protect_on_q  <= 1'b1;
    end else begin
      rsp_valid_q <= 1'b0;
      case (st_q)
        H_IDLE: begin
          if (req_take) begin
            op_q     <= epc_op_e'(req_op);
            addr_q   <= req_addr;
            data_q   <= req_wdata;
            last_q   <= req_last;
            step_q   <= '0;
            nbytes_q <= '0;
            // every write or protect begins with the enable sequence
            st_q     <= (epc_op_e'(req_op) == EPC_OP_READ) ? H_READ : H_CMD;
          end
        end
        H_CMD: begin
          // steps go back to back, nothing between them
          if (bc_done) begin
            if (step_q == nsteps - 3'h1) begin
              tmr_q <= '0;
              if (op_q == EPC_OP_WRITE) begin
                st_q <= H_DATA;
              end else begin
                // zero data bytes: device still changes state at end of cycle
                st_q <= H_POLL;
              end
            end else begin
              step_q <= step_q + 3'h1;
            end
          end
        end
        H_DATA: begin
          if (bc_done) begin
            nbytes_q    <= nbytes_q + 8'h01;
            last_addr_q <= addr_q;
            last_data_q <= data_q;
            tmr_q       <= '0;
            st_q        <= H_WAIT;
          end
        end
        H_WAIT: begin
          tmr_q <= tmr_q + CNT_W'(1);
          if (req_take) begin
            addr_q <= req_addr;
            data_q <= req_wdata;
            last_q <= req_last;
            st_q   <= H_DATA;
          // a refused request closes the page at once
          end else if (last_q || page_full || load_late || req_valid) begin
            tmr_q <= '0;
            st_q  <= H_POLL;
          end
        end
        H_POLL: begin
          tmr_q <= tmr_q + CNT_W'(1);
          if (bc_done) begin
            // commands only: wait out the program time
            if ((op_q == EPC_OP_WRITE && poll_ok) || prog_over) begin
              protect_on_q  <= !is_unprot;
              rsp_timeout_q <= (op_q == EPC_OP_WRITE) && !poll_ok;
              rsp_valid_q   <= 1'b1;
              st_q          <= H_IDLE;
            end
          end
        end
        default: begin
          if (bc_done) begin
            rsp_rdata_q   <= bc_rdata;
            rsp_timeout_q <= 1'b0;
            rsp_valid_q   <= 1'b1;
            st_q          <= H_IDLE;
          end
        end
      endcase
    end
  end

  a_cmd_precedes: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_q == H_CMD && bc_done && step_q == 3'h2 && op_q == EPC_OP_WRITE) |=> st_q == H_DATA)
    else $error("data did not follow enable sequence");
  a_page_limit: assert property (@(posedge clk_sys) disable iff (!resetn)
    nbytes_q <= 8'(PAGE_MAX)) else $error("page overrun");
  a_no_write_on_read: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!lane_select_n && !out_en_n) |-> wr_en_n) else $error("write during read strobe");

endmodule : epc_host

// *** rtl/epc_pkg.sv ***
/*
  constants for the eeprom host controller: bus timing counts, widths,
  page size and operation codes.
  assumes a 100 mhz clk_sys.
*/
package epc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;

  // ----------------------------------------------------------------
  // bus timing
  // ----------------------------------------------------------------
  localparam int unsigned WRITE_PULSE_NS   = 100;
  localparam int unsigned WE_RECOVERY_NS   = 50;
  localparam int unsigned READ_ACCESS_NS   = 200;
  localparam int unsigned BYTE_LOAD_MAX_US = 150;
  localparam int unsigned PROGRAM_CYCLE_MS = 10;

  localparam int unsigned WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WE_RECOVERY_CYC = (WE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BYTE_LOAD_CYC   = (BYTE_LOAD_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned PROGRAM_CYC     = (PROGRAM_CYCLE_MS * 1000000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // widths and page
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 17;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned PAGE_MAX  = 128;
  localparam int unsigned CNT_W     = 24;

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EPC_OP_READ    = 2'h0,
    EPC_OP_WRITE   = 2'h1,
    EPC_OP_PROTECT = 2'h2,
    EPC_OP_UNPROT  = 2'h3
  } epc_op_e;

endpackage : epc_pkg

// *** rtl/epc_bus_cycle.sv ***
/*
  one bus cycle on the eeprom pins: a write strobe or a timed read.
  assumes the caller holds address, data and kind stable while busy.
*/
`timescale 1ns/1ns
module epc_bus_cycle
  import epc_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  // request
  input  wire logic              start,
  input  wire logic              is_write,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic                   done,
  output logic [DATA_W-1:0]      rdata_q,
  // pins
  output logic [ADDR_W-1:0]      mem_addr_q,
  output logic                   chip_sel_n_q,
  output logic                   out_en_n_q,
  output logic                   wr_en_n_q,
  output logic [DATA_W-1:0]      command_byte_lines_o,
  output logic                   command_byte_lines_oe,
  input  wire logic [DATA_W-1:0] command_byte_lines_i
);

  typedef enum logic [1:0] {
    BC_IDLE = 2'h0,
    BC_STRB = 2'h1,
    BC_RECV = 2'h2
  } bc_state_e;

  bc_state_e         st_q;
  logic [7:0]        cnt_q;
  logic              wr_q;
  logic [DATA_W-1:0] dout_q;
  logic [DATA_W-1:0] sync1_q;
  logic [DATA_W-1:0] sync2_q;

  wire strobe_end = (st_q == BC_STRB) &&
                    (cnt_q == 8'(wr_q ? WRITE_PULSE_CYC + 2 : READ_ACCESS_CYC + 2));
  wire recv_end   = (st_q == BC_RECV) && (cnt_q == 8'(WE_RECOVERY_CYC));

  assign done                  = recv_end;
  assign command_byte_lines_o  = dout_q;
  // drive only while writing, never during a read strobe
  assign command_byte_lines_oe = wr_q && (st_q != BC_IDLE);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= command_byte_lines_i;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q         <= BC_IDLE;
      cnt_q        <= '0;
      wr_q         <= 1'b0;
      dout_q       <= '0;
      rdata_q      <= '0;
      mem_addr_q   <= '0;
      chip_sel_n_q <= 1'b1;
      out_en_n_q   <= 1'b1;
      wr_en_n_q    <= 1'b1;
    end else begin
      case (st_q)
        BC_IDLE: begin
          if (start) begin
            st_q         <= BC_STRB;
            cnt_q        <= '0;
            wr_q         <= is_write;
            mem_addr_q   <= addr;
            dout_q       <= wdata;
            chip_sel_n_q <= 1'b0;
            // write: oe high, we low; read: oe low, we high
            out_en_n_q   <= is_write;
            wr_en_n_q    <= !is_write;
          end
        end
        BC_STRB: begin
          cnt_q <= cnt_q + 8'h01;
          if (strobe_end) begin
            st_q         <= BC_RECV;
            cnt_q        <= '0;
            chip_sel_n_q <= 1'b1;
            out_en_n_q   <= 1'b1;
            wr_en_n_q    <= 1'b1;
            if (!wr_q) begin
              rdata_q <= sync2_q;
            end
          end
        end
        default: begin
          cnt_q <= cnt_q + 8'h01;
          if (recv_end) begin
            st_q <= BC_IDLE;
            wr_q <= 1'b0;
          end
        end
      endcase
    end
  end

  a_pins_exclusive: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(out_en_n_q == 1'b0 && wr_en_n_q == 1'b0)) else $error("oe and we low together");
  a_drive_on_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    command_byte_lines_oe |-> out_en_n_q) else $error("data driven while oe low");

endmodule : epc_bus_cycle

// *** tb/epc_dev_model.sv ***
/*
  behavioural model of one protected eeprom lane facing epc_host.
  assumes only the host drives the strobes; all times are in ns.
*/
`timescale 1ns/1ns
module epc_dev_model
  import epc_pkg::*;
#(
  parameter int unsigned FAST_NS = 1000,
  parameter int unsigned SLOW_NS = 20000
)(
  // scenario control
  input  wire logic              slow,
  // pins
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              lane_select_n,
  input  wire logic              out_en_n,
  input  wire logic              wr_en_n,
  input  wire logic [DATA_W-1:0] host_d,
  input  wire logic              host_oe,
  output logic [DATA_W-1:0]      bus_d
);
  localparam logic [ADDR_W-1:0] EN_A [3]  = '{17'h05555, 17'h02aaa, 17'h05555};
  localparam logic [DATA_W-1:0] EN_D [3]  = '{8'haa, 8'h55, 8'ha0};
  localparam logic [ADDR_W-1:0] DIS_A [6] = '{17'h05555, 17'h02aaa, 17'h05555, 17'h05555, 17'h02aaa, 17'h05555};
  localparam logic [DATA_W-1:0] DIS_D [6] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55, 8'h20};

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] pq_d [$];
  logic [ADDR_W-1:0] pq_a [$];
  logic [ADDR_W-1:0] wa, la, pa;
  logic [DATA_W-1:0] wd, ld, dout, mem_rd;
  logic [DATA_W-1:0] last_d = 8'h00;
  logic              prot = 1'b1, win = 1'b0, busy = 1'b0, unprot = 1'b0, tog = 1'b0;
  int                en_s = 0, dis_s = 0;
  time               t_fall = 0, t_end = 0;

  wire wr_act = !lane_select_n && !wr_en_n && out_en_n;
  wire rd_act = !lane_select_n && !out_en_n && wr_en_n;

  initial foreach (mem[i]) mem[i] = 8'hff;

  always @(posedge wr_act) begin
    wa = mem_addr;
    t_fall = $time;
  end
  always @(posedge wr_act or host_d) if (wr_act) wd = host_d;

  always @(negedge wr_act) begin : wr_end
    logic cmd;
    cmd = 1'b0;
    if (!busy) begin
      if (wa == EN_A[en_s] && wd == EN_D[en_s]) begin en_s++; cmd = 1'b1; end
      else en_s = (wa == EN_A[0] && wd == EN_D[0]) ? 1 : 0;
      if (wa == DIS_A[dis_s] && wd == DIS_D[dis_s]) begin dis_s++; cmd = 1'b1; end
      else dis_s = (wa == DIS_A[0] && wd == DIS_D[0]) ? 1 : 0;
      if (en_s == 3) begin
        en_s = 0; dis_s = 0; prot = 1'b1; win = 1'b1;
      end else if (dis_s == 6) begin
        en_s = 0; dis_s = 0; win = 1'b0; unprot = 1'b1; busy = 1'b1; t_end = $time + FAST_NS;
      end else if (!cmd && (win || !prot)) begin
        if (pq_a.size() == 0) pa = wa;
        if (wa[ADDR_W-1:7] == pa[ADDR_W-1:7] && pq_a.size() < PAGE_MAX) begin
          pq_a.push_back(wa); pq_d.push_back(wd); la = wa; ld = wd; win = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // load window and programming timers
  // ----------------------------------------------------------------
  always #100 begin
    if (win && $time - t_fall >= BYTE_LOAD_MAX_US * 1000) begin
      win = 1'b0; busy = 1'b1; t_end = $time + (slow ? SLOW_NS : FAST_NS);
    end
    if (busy && $time >= t_end) begin
      while (pq_a.size() > 0) mem[pq_a.pop_front()] = pq_d.pop_front();
      if (unprot) prot = 1'b0;
      unprot = 1'b0; busy = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read side and data line resolution
  // ----------------------------------------------------------------
  always @(negedge rd_act) if (busy || win) tog = ~tog;
  assign mem_rd = mem[mem_addr];
  assign dout = ((busy || win) && mem_addr == la) ? {~ld[7], tog, ld[5:0]} :
                (busy || win) ? {mem_rd[7], tog, mem_rd[5:0]} : mem_rd;
  always @(host_oe or rd_act or host_d or dout) if (host_oe) last_d = host_d; else if (rd_act) last_d = dout;
  always @* begin
    if (host_oe && rd_act) bus_d = 'x;
    else if (host_oe) bus_d = host_d;
    else if (rd_act) bus_d = dout;
    else bus_d = ~last_d;
  end
endmodule : epc_dev_model

// *** tb/tb.sv ***
/*
  self-checking bench for epc_host against the eeprom lane model.
  assumes the short PROG_CYC below covers the model's byte load window plus
  its fast programming time, but not its slow one.
*/
`timescale 1ns/1ns
module tb;
  import epc_pkg::*;
  // load window 15000 cycles, fast program 100, slow program 2000
  localparam int unsigned PROG_SMALL = BYTE_LOAD_CYC + 600;
  localparam int unsigned WATCH_CYC  = 7 * BYTE_LOAD_CYC;
  typedef struct { logic [1:0] op; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d; logic [DATA_W-1:0] rd; logic pr; } epc_row_s;

  logic              clk_sys = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_last = 1'b0, slow = 1'b0;
  logic [1:0]        req_op = 2'h0;
  logic [ADDR_W-1:0] req_addr = 17'h00000;
  logic [DATA_W-1:0] req_wdata = 8'h00;
  logic              req_ready, rsp_valid_q, rsp_timeout_q, protect_on_q;
  logic              lane_select_n, out_en_n, wr_en_n, dq_oe;
  logic [DATA_W-1:0] rsp_rdata_q, dq_o, dq_i;
  logic [ADDR_W-1:0] mem_addr;
  int                error_cnt = 0, checked = 0;
  epc_row_s rows [5] = '{
    '{EPC_OP_WRITE,   17'h00100, 8'h5a, 8'h00, 1'b1},
    '{EPC_OP_READ,    17'h00100, 8'h00, 8'h5a, 1'b1},
    '{EPC_OP_UNPROT,  17'h00000, 8'h00, 8'h00, 1'b0},
    '{EPC_OP_PROTECT, 17'h00000, 8'h00, 8'h00, 1'b1},
    '{EPC_OP_READ,    17'h00100, 8'h00, 8'h5a, 1'b1}};
  logic [ADDR_W-1:0] pg_a [3] = '{17'h00200, 17'h0027f, 17'h00280};
  logic [DATA_W-1:0] pg_d [3] = '{8'h11, 8'hc3, 8'h3c};

  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  epc_host #(.PROG_CYC(PROG_SMALL)) epc_host_i (
    .clk_sys(clk_sys), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_last(req_last), .rsp_valid_q(rsp_valid_q),
    .rsp_rdata_q(rsp_rdata_q), .rsp_timeout_q(rsp_timeout_q), .protect_on_q(protect_on_q),
    .mem_addr(mem_addr), .lane_select_n(lane_select_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n),
    .command_byte_lines_o(dq_o), .command_byte_lines_oe(dq_oe), .command_byte_lines_i(dq_i));

  epc_dev_model epc_dev_model_i (
    .slow(slow), .mem_addr(mem_addr), .lane_select_n(lane_select_n), .out_en_n(out_en_n),
    .wr_en_n(wr_en_n), .host_d(dq_o), .host_oe(dq_oe), .bus_d(dq_i));

  task automatic check(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude;
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  // one request, held until the edge that takes it
  task automatic issue(input logic [1:0] op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic last);
    int n = 0;
    @(posedge clk_sys);
    #1;
    req_op = op; req_addr = a; req_wdata = d; req_last = last; req_valid = 1'b1;
    while (n < 20000) begin
      @(negedge clk_sys);
      if (req_ready === 1'b1) break;
      n++;
    end
    check("req_ready", {7'h0, req_ready}, 8'h01);
    @(posedge clk_sys);
    #1 req_valid = 1'b0;
  endtask : issue

  // leaves the bench at the negedge where the answer stands
  task automatic await_rsp;
    int n = 0;
    while (rsp_valid_q !== 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    check("rsp_valid", {7'h0, rsp_valid_q}, 8'h01);
  endtask : await_rsp

  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    check("idle strobes", {5'h0, lane_select_n, out_en_n, wr_en_n}, 8'h07);
    check("reset protect", {7'h0, protect_on_q}, 8'h01);
    resetn = 1'b1;
    // ----------------------------------------------------------------
    // ordinary operations
    // ----------------------------------------------------------------
    foreach (rows[i]) begin
      issue(rows[i].op, rows[i].a, rows[i].d, 1'b1);
      await_rsp();
      if (rows[i].op == EPC_OP_READ) check("read data", rsp_rdata_q, rows[i].rd);
      else check("timeout", {7'h0, rsp_timeout_q}, 8'h00);
      check("host protect", {7'h0, protect_on_q}, {7'h0, rows[i].pr});
      check("device protect", {7'h0, epc_dev_model_i.prot}, {7'h0, rows[i].pr});
    end
    // ----------------------------------------------------------------
    // page of two bytes, then a byte in the next page
    // ----------------------------------------------------------------
    issue(EPC_OP_WRITE, pg_a[0], pg_d[0], 1'b0);
    issue(EPC_OP_WRITE, pg_a[1], pg_d[1], 1'b0);
    issue(EPC_OP_WRITE, pg_a[2], pg_d[2], 1'b1);
    await_rsp();
    check("page timeout", {7'h0, rsp_timeout_q}, 8'h00);
    foreach (pg_a[i]) begin
      issue(EPC_OP_READ, pg_a[i], 8'h00, 1'b1);
      await_rsp();
      check("page data", rsp_rdata_q, pg_d[i]);
    end
    // ----------------------------------------------------------------
    // programming slower than the poll limit
    // ----------------------------------------------------------------
    slow = 1'b1;
    issue(EPC_OP_WRITE, 17'h00300, 8'h81, 1'b1);
    await_rsp();
    check("slow timeout", {7'h0, rsp_timeout_q}, 8'h01);
    repeat (3000) @(posedge clk_sys);
    #1 slow = 1'b0;
    issue(EPC_OP_READ, 17'h00300, 8'h00, 1'b1);
    await_rsp();
    check("late data", rsp_rdata_q, 8'h81);
    // ----------------------------------------------------------------
    // reset in the middle of a read
    // ----------------------------------------------------------------
    issue(EPC_OP_READ, 17'h00100, 8'h00, 1'b1);
    repeat (5) @(posedge clk_sys);
    #1 resetn = 1'b0;
    #1;
    check("abort strobes", {5'h0, lane_select_n, out_en_n, wr_en_n}, 8'h07);
    check("abort drive", {7'h0, dq_oe}, 8'h00);
    @(posedge clk_sys);
    #1 resetn = 1'b1;
    issue(EPC_OP_READ, 17'h00100, 8'h00, 1'b1);
    await_rsp();
    check("read after reset", rsp_rdata_q, 8'h5a);
    conclude();
  end

  // seven load windows: six program waits plus polling and reads, with margin
  initial begin
    repeat (WATCH_CYC) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end
endmodule : tb
